// *** logic/flb_pkg.sv ***
// Functional notes
// - host loads one password portion per command
// - host uses write-enable-controlled guard writes
// - host exits every entered set with exit command
// - host enters a set before protection work
package flb_pkg;

  // ----------------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------------
  localparam int CLK_MHZ     = 100;
  localparam int SYNC_STAGES = 2;
  localparam int T_WE_NS     = 50;
  localparam int T_RD_NS     = 80;
  localparam int T_REC_NS    = 30;
  localparam int WE_CYC      = (T_WE_NS * CLK_MHZ + 999) / 1000;
  // read strobe also covers the two-flop input synchroniser
  localparam int RD_CYC      = (T_RD_NS * CLK_MHZ + 999) / 1000 + SYNC_STAGES;
  localparam int REC_CYC     = (T_REC_NS * CLK_MHZ + 999) / 1000;

  // ----------------------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------------------
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_ADDR   = 8'h04;
  localparam logic [7:0] REG_WDATA  = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_RDATA  = 8'h10;
  localparam int CTRL_OP_LSB   = 0;
  localparam int CTRL_GO_BIT   = 4;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  localparam int STAT_ERR_BIT  = 2;
  localparam int STAT_SET_BIT  = 3;

  // ----------------------------------------------------------------------------
  // flash command words
  // ----------------------------------------------------------------------------
  localparam logic [22:0] UNLOCK_A1 = 23'h000555;
  localparam logic [22:0] UNLOCK_A2 = 23'h0002AA;
  localparam logic [22:0] ANY_ADDR  = 23'h000000;
  localparam logic [15:0] UNLOCK_D1 = 16'h00AA;
  localparam logic [15:0] UNLOCK_D2 = 16'h0055;
  localparam logic [15:0] SET_LOCK  = 16'h0040;
  localparam logic [15:0] SET_PWD   = 16'h0060;
  localparam logic [15:0] SET_NV    = 16'h00C0;
  localparam logic [15:0] SET_FRZ   = 16'h0050;
  localparam logic [15:0] SET_VOL   = 16'h00E0;
  localparam logic [15:0] PROG_CMD  = 16'h00A0;
  localparam logic [15:0] CLR_CMD1  = 16'h0080;
  localparam logic [15:0] CLR_CMD2  = 16'h0030;
  localparam logic [15:0] EXIT_CMD1 = 16'h0090;
  localparam logic [15:0] EXIT_CMD2 = 16'h0000;

  // ----------------------------------------------------------------------------
  // types
  // ----------------------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_ENTER_LOCK = 4'h0,
    OP_ENTER_PWD  = 4'h1,
    OP_ENTER_NV   = 4'h2,
    OP_ENTER_FRZ  = 4'h3,
    OP_ENTER_VOL  = 4'h4,
    OP_PROGRAM    = 4'h5,
    OP_READ       = 4'h6,
    OP_CLEAR_ALL  = 4'h7,
    OP_EXIT       = 4'h8
  } flb_op_t;

  typedef struct packed {
    logic [22:0] addr;
    logic [15:0] dq;
    logic        dqOe;
    logic        ceN;
    logic        oeN;
    logic        weN;
  } flb_pins_t;

  typedef struct packed {
    logic        isRead;
    logic [22:0] addr;
    logic [15:0] data;
  } flb_step_t;

endpackage

// *** logic/flb_bus_cycle.sv ***
`timescale 1ns/1ps
module flb_bus_cycle #(
  parameter int WE_CYC  = flb_pkg::WE_CYC,
  parameter int RD_CYC  = flb_pkg::RD_CYC,
  parameter int REC_CYC = flb_pkg::REC_CYC
) (
  // clock and reset
  input  wire logic              ref_clk,
  input  wire logic              nrst,
  input  wire logic              clkEn,
  // request
  input  wire logic              start,
  input  wire flb_pkg::flb_step_t step,
  output logic                   done,
  output logic [15:0]            rdWord,
  // flash pins
  output flb_pkg::flb_pins_t     pins,
  input  wire logic [15:0]       dqIn
);

  // ----------------------------------------------------------------------------
  // one asynchronous bus cycle
  // ----------------------------------------------------------------------------
  typedef enum logic [2:0] {C_IDLE, C_SETUP, C_STROBE, C_HOLD, C_REC} flb_cyc_t;

  flb_cyc_t           st_r, st_nxt;
  logic [7:0]         cnt_r, cnt_nxt;
  flb_pkg::flb_step_t step_r, step_nxt;
  flb_pkg::flb_pins_t pins_r, pins_nxt;
  logic [15:0]        rd_r, rd_nxt, sync1_r, sync2_r;
  logic               done_r, done_nxt;

  always_comb begin
    st_nxt   = st_r;
    cnt_nxt  = cnt_r;
    step_nxt = step_r;
    rd_nxt   = rd_r;
    done_nxt = 1'b0;
    unique case (st_r)
      C_IDLE: if (start) begin
        step_nxt = step;
        st_nxt   = C_SETUP;
      end
      C_SETUP: begin
        st_nxt  = C_STROBE;
        cnt_nxt = step_r.isRead ? 8'(RD_CYC - 1) : 8'(WE_CYC - 1);
      end
      C_STROBE: if (cnt_r == 8'h00) begin
        if (step_r.isRead) rd_nxt = sync2_r;
        st_nxt = C_HOLD;
      end else begin
        cnt_nxt = cnt_r - 8'h01;
      end
      C_HOLD: begin
        st_nxt  = C_REC;
        cnt_nxt = 8'(REC_CYC - 1);
      end
      C_REC: if (cnt_r == 8'h00) begin
        st_nxt   = C_IDLE;
        done_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r - 8'h01;
      end
    endcase
    // chip enable wraps the strobe on both sides, so writes are write-enable timed
    pins_nxt.addr = step_nxt.addr;
    pins_nxt.dq   = step_nxt.data;
    pins_nxt.ceN  = !(st_nxt == C_SETUP || st_nxt == C_STROBE || st_nxt == C_HOLD);
    pins_nxt.weN  = !(st_nxt == C_STROBE && !step_nxt.isRead);
    pins_nxt.oeN  = !(st_nxt == C_STROBE && step_nxt.isRead);
    pins_nxt.dqOe = !pins_nxt.ceN && !step_nxt.isRead;
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      st_r    <= C_IDLE;
      cnt_r   <= 8'h00;
      step_r  <= '0;
      pins_r  <= '{addr: 23'h000000, dq: 16'h0000, dqOe: 1'b0, ceN: 1'b1, oeN: 1'b1, weN: 1'b1};
      rd_r    <= 16'h0000;
      done_r  <= 1'b0;
      sync1_r <= 16'h0000;
      sync2_r <= 16'h0000;
    end else if (clkEn) begin
      st_r    <= st_nxt;
      cnt_r   <= cnt_nxt;
      step_r  <= step_nxt;
      pins_r  <= pins_nxt;
      rd_r    <= rd_nxt;
      done_r  <= done_nxt;
      sync1_r <= dqIn;
      sync2_r <= sync1_r;
    end
  end

  assign pins   = pins_r;
  assign rdWord = rd_r;
  assign done   = done_r;

  // ----------------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  a_we_inside_ce: assert property (!pins_r.weN |-> !pins_r.ceN && $past(!pins_r.ceN))
    else $error("write strobe not inside chip enable");
  a_ce_after_we: assert property ($rose(pins_r.weN) |-> !pins_r.ceN)
    else $error("chip enable released with write strobe");
  a_cycle_bounded: assert property (clkEn && start && st_r == C_IDLE |-> ##[4:40] done_r)
    else $error("bus cycle did not finish in time");

endmodule

// *** logic/flb_host_ctrl.sv ***
`timescale 1ns/1ps
module flb_host_ctrl (
  // clock and reset
  input  wire logic               ref_clk,
  input  wire logic               nrst,
  input  wire logic               clkEn,
  // apb slave
  input  wire logic [7:0]         paddr,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [31:0]        pwdata,
  output logic [31:0]             prdata,
  output logic                    pready,
  output logic                    pslverr,
  // flash pins
  output flb_pkg::flb_pins_t      flashPins,
  input  wire logic [15:0]        flashDqIn
);

  // ----------------------------------------------------------------------------
  // sequences
  // ----------------------------------------------------------------------------
  function automatic logic [1:0] lastIdx(input flb_pkg::flb_op_t op);
    unique case (op)
      flb_pkg::OP_READ:                         lastIdx = 2'd0;
      flb_pkg::OP_PROGRAM, flb_pkg::OP_CLEAR_ALL,
      flb_pkg::OP_EXIT:                         lastIdx = 2'd1;
      default:                                  lastIdx = 2'd2;
    endcase
  endfunction

  function automatic logic isEnter(input flb_pkg::flb_op_t op);
    isEnter = op inside {flb_pkg::OP_ENTER_LOCK, flb_pkg::OP_ENTER_PWD, flb_pkg::OP_ENTER_NV,
                         flb_pkg::OP_ENTER_FRZ, flb_pkg::OP_ENTER_VOL};
  endfunction

  // upper address and data are zero in every unlock and command word
  function automatic flb_pkg::flb_step_t stepOf(input flb_pkg::flb_op_t op, input logic [1:0] idx,
                                                input logic [22:0] ad, input logic [15:0] dat);
    logic [15:0] code;
    code = flb_pkg::SET_VOL;
    unique case (op)
      flb_pkg::OP_ENTER_LOCK: code = flb_pkg::SET_LOCK;
      flb_pkg::OP_ENTER_PWD:  code = flb_pkg::SET_PWD;
      flb_pkg::OP_ENTER_NV:   code = flb_pkg::SET_NV;
      flb_pkg::OP_ENTER_FRZ:  code = flb_pkg::SET_FRZ;
      default:                code = flb_pkg::SET_VOL;
    endcase
    unique case (op)
      flb_pkg::OP_PROGRAM:   stepOf = (idx == 2'd0) ? '{1'b0, flb_pkg::ANY_ADDR, flb_pkg::PROG_CMD}
                                                    : '{1'b0, ad, dat};
      flb_pkg::OP_READ:      stepOf = '{1'b1, ad, 16'h0000};
      flb_pkg::OP_CLEAR_ALL: stepOf = (idx == 2'd0) ? '{1'b0, flb_pkg::ANY_ADDR, flb_pkg::CLR_CMD1}
                                                    : '{1'b0, flb_pkg::ANY_ADDR, flb_pkg::CLR_CMD2};
      flb_pkg::OP_EXIT:      stepOf = (idx == 2'd0) ? '{1'b0, flb_pkg::ANY_ADDR, flb_pkg::EXIT_CMD1}
                                                    : '{1'b0, flb_pkg::ANY_ADDR, flb_pkg::EXIT_CMD2};
      default: begin
        unique case (idx)
          2'd0:    stepOf = '{1'b0, flb_pkg::UNLOCK_A1, flb_pkg::UNLOCK_D1};
          2'd1:    stepOf = '{1'b0, flb_pkg::UNLOCK_A2, flb_pkg::UNLOCK_D2};
          default: stepOf = '{1'b0, flb_pkg::UNLOCK_A1, code};
        endcase
      end
    endcase
  endfunction

  // ----------------------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------------------
  typedef enum logic [1:0] {S_IDLE, S_ISSUE, S_WAIT} flb_state_t;

  flb_state_t       st_r, st_nxt;
  flb_pkg::flb_op_t op_r, op_nxt;
  logic [1:0]       idx_r, idx_nxt;
  logic [22:0]      addr_r, addr_nxt;
  logic [15:0]      wdata_r, wdata_nxt, rdata_r, rdata_nxt;
  logic             done_r, done_nxt, err_r, err_nxt, inSet_r, inSet_nxt;
  logic             wrEn, hit, goReq, statClrDone, statClrErr, cycDone, finish;
  logic [15:0]      cycRd;
  flb_pkg::flb_op_t reqOp;
  flb_pkg::flb_step_t curStep;

  // zero wait states; a frozen block stalls the bus instead of dropping writes
  assign pready  = clkEn;
  assign wrEn    = psel && penable && pwrite && clkEn;
  assign hit     = paddr inside {flb_pkg::REG_CTRL, flb_pkg::REG_ADDR, flb_pkg::REG_WDATA,
                                 flb_pkg::REG_STATUS, flb_pkg::REG_RDATA};
  assign pslverr = psel && penable && !hit;
  assign reqOp   = flb_pkg::flb_op_t'(pwdata[flb_pkg::CTRL_OP_LSB +: 4]);
  assign goReq   = wrEn && paddr == flb_pkg::REG_CTRL && pwdata[flb_pkg::CTRL_GO_BIT];
  assign statClrDone = wrEn && paddr == flb_pkg::REG_STATUS && pwdata[flb_pkg::STAT_DONE_BIT];
  assign statClrErr  = wrEn && paddr == flb_pkg::REG_STATUS && pwdata[flb_pkg::STAT_ERR_BIT];
  assign finish  = st_r == S_WAIT && cycDone && idx_r == lastIdx(op_r);
  // the bus step in flight, named once so its fields can be selected
  assign curStep = stepOf(op_r, idx_r, addr_r, wdata_r);

  always_comb begin
    prdata = 32'h00000000;
    unique case (paddr)
      flb_pkg::REG_CTRL:   prdata = {28'h0000000, op_r};
      flb_pkg::REG_ADDR:   prdata = {9'h000, addr_r};
      flb_pkg::REG_WDATA:  prdata = {16'h0000, wdata_r};
      flb_pkg::REG_STATUS: prdata = {28'h0000000, inSet_r, err_r, done_r, st_r != S_IDLE};
      flb_pkg::REG_RDATA:  prdata = {16'h0000, rdata_r};
      default:             prdata = 32'h00000000;
    endcase
  end

  // ----------------------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------------------
  always_comb begin
    st_nxt    = st_r;
    op_nxt    = op_r;
    idx_nxt   = idx_r;
    addr_nxt  = addr_r;
    wdata_nxt = wdata_r;
    rdata_nxt = rdata_r;
    done_nxt  = done_r && !statClrDone;
    err_nxt   = err_r && !statClrErr;
    inSet_nxt = inSet_r;
    if (st_r == S_IDLE && wrEn && paddr == flb_pkg::REG_ADDR) addr_nxt = pwdata[22:0];
    if (st_r == S_IDLE && wrEn && paddr == flb_pkg::REG_WDATA) wdata_nxt = pwdata[15:0];
    unique case (st_r)
      S_IDLE: if (goReq) begin
        // work only inside a set, and a new set only after the exit
        if (isEnter(reqOp) == inSet_r || reqOp > flb_pkg::OP_EXIT) begin
          err_nxt = 1'b1;
        end else begin
          op_nxt  = reqOp;
          idx_nxt = 2'd0;
          st_nxt  = S_ISSUE;
        end
      end
      S_ISSUE: st_nxt = S_WAIT;
      S_WAIT: if (cycDone) begin
        if (curStep.isRead) rdata_nxt = cycRd;
        if (finish) begin
          st_nxt   = S_IDLE;
          done_nxt = 1'b1;
          if (isEnter(op_r)) inSet_nxt = 1'b1;
          if (op_r == flb_pkg::OP_EXIT) inSet_nxt = 1'b0;
        end else begin
          idx_nxt = idx_r + 2'd1;
          st_nxt  = S_ISSUE;
        end
      end
      default: st_nxt = S_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      st_r    <= S_IDLE;
      op_r    <= flb_pkg::OP_ENTER_LOCK;
      idx_r   <= 2'd0;
      addr_r  <= 23'h000000;
      wdata_r <= 16'h0000;
      rdata_r <= 16'h0000;
      done_r  <= 1'b0;
      err_r   <= 1'b0;
      inSet_r <= 1'b0;
    end else if (clkEn) begin
      st_r    <= st_nxt;
      op_r    <= op_nxt;
      idx_r   <= idx_nxt;
      addr_r  <= addr_nxt;
      wdata_r <= wdata_nxt;
      rdata_r <= rdata_nxt;
      done_r  <= done_nxt;
      err_r   <= err_nxt;
      inSet_r <= inSet_nxt;
    end
  end

  flb_bus_cycle u_cycle (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .clkEn   (clkEn),
    .start   (st_r == S_ISSUE),
    .step    (curStep),
    .done    (cycDone),
    .rdWord  (cycRd),
    .pins    (flashPins),
    .dqIn    (flashDqIn)
  );

  // ----------------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  a_refuse_outside_set: assert property (clkEn && st_r == S_IDLE && goReq && !inSet_r && !isEnter(reqOp)
                                         |=> err_r && st_r == S_IDLE)
    else $error("operation started outside a command set");
  a_exit_leaves_set: assert property (clkEn && finish && op_r == flb_pkg::OP_EXIT |=> !inSet_r && done_r)
    else $error("exit did not leave the command set");
  a_no_reenter: assert property (clkEn && st_r == S_IDLE && goReq && inSet_r && isEnter(reqOp)
                                 |=> st_r == S_IDLE && err_r)
    else $error("second enter accepted without exit");
  a_one_portion: assert property (st_r != S_IDLE && op_r == flb_pkg::OP_PROGRAM |-> idx_r <= 2'd1)
    else $error("program issued more than one data word");
  a_upper_zero: assert property (st_r == S_ISSUE && (isEnter(op_r) || op_r == flb_pkg::OP_EXIT)
                                 |-> curStep.data[15:8] == 8'h00
                                     && curStep.addr[22:16] == 7'h00)
    else $error("command word carries upper bits");
  a_read_capture: assert property (clkEn && st_r == S_WAIT && cycDone && op_r == flb_pkg::OP_READ
                                   |=> rdata_r == $past(cycRd) && done_r)
    else $error("read word not captured");

  c_enter: cover property (finish && isEnter(op_r));
  c_program: cover property (finish && op_r == flb_pkg::OP_PROGRAM);
  c_read: cover property (finish && op_r == flb_pkg::OP_READ);
  c_exit: cover property (finish && op_r == flb_pkg::OP_EXIT);

endmodule

// *** test/flb_flash_model.sv ***
`timescale 1ns/1ps
module flb_flash_model (
  // host pins
  input  wire flb_pkg::flb_pins_t pins,
  output logic [15:0]             dqOut
);
  logic [2:0]  lockBits;
  logic        frzBit;
  logic [3:0]  nvBits;
  logic [3:0]  volBits;
  logic [15:0] pwd [4];
  logic [2:0]  setSel;
  logic [1:0]  unlockCnt;
  logic        progArm;
  logic        clrArm;
  logic        exitArm;
  logic [15:0] rdVal;
  logic [15:0] lastOut;
  // only low bits are decoded in command cycles
  wire logic [10:0] a   = pins.addr[10:0];
  wire logic [7:0]  d   = pins.dq[7:0];
  wire logic [1:0]  blk = pins.addr[17:16];

  initial begin
    lockBits = 3'h7;
    frzBit = 1'b1;
    nvBits = 4'hF;
    volBits = 4'hF;
    setSel = 3'h0;
    unlockCnt = 2'h0;
    {progArm, clrArm, exitArm} = 3'h0;
    lastOut = 16'h0000;
  end

  // ----------------------------------------------------------------------------
  // command decode, writes latch on the rising write strobe
  // ----------------------------------------------------------------------------
  // programs finish at once, on the rising write strobe of their data word
  always @(posedge pins.weN) begin
    if (!pins.ceN) begin
      if (progArm) begin
        progArm = 1'b0;
        case (setSel)
          // an abort leaves every bit as it was
          3'h1: if (!(!d[2] && !lockBits[1]) && !(!d[1] && !lockBits[2])) lockBits = lockBits & d[2:0];
          3'h2: pwd[a[1:0]] = pins.dq;
          3'h3: if (frzBit && d == 8'h00 && blk != 2'h0) nvBits[blk] = 1'b0;
          3'h4: if (d == 8'h00) frzBit = 1'b0;
          3'h5: if (blk != 2'h0) volBits[blk] = d[0];
          default: ;
        endcase
      end else if (clrArm) begin
        clrArm = 1'b0;
        if (d == 8'h30 && setSel == 3'h3 && frzBit) begin
          nvBits = 4'h0;
          nvBits = 4'hF;
        end
      end else if (exitArm) begin
        exitArm = 1'b0;
        if (d == 8'h00) setSel = 3'h0;
      end else if (setSel != 3'h0) begin
        progArm = (d == 8'hA0);
        clrArm = (d == 8'h80);
        exitArm = (d == 8'h90);
      end else if (unlockCnt == 2'h0) begin
        unlockCnt = (a == 11'h555 && d == 8'hAA) ? 2'h1 : 2'h0;
      end else if (unlockCnt == 2'h1) begin
        unlockCnt = (a == 11'h2AA && d == 8'h55) ? 2'h2 : 2'h0;
      end else begin
        unlockCnt = 2'h0;
        if (a == 11'h555) begin
          case (d)
            8'h40: setSel = 3'h1;
            8'h60: setSel = 3'h2;
            8'hC0: setSel = 3'h3;
            8'h50: setSel = 3'h4;
            8'hE0: setSel = 3'h5;
            default: ;
          endcase
        end
      end
    end
  end

  // ----------------------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------------------
  always_comb begin
    case (setSel)
      3'h1: rdVal = {13'h1FFF, lockBits};
      3'h2: rdVal = pwd[a[1:0]];
      3'h3: rdVal = {15'h0000, ~nvBits[blk]};
      3'h4: rdVal = {15'h0000, frzBit};
      3'h5: rdVal = {15'h0000, ~volBits[blk]};
      default: rdVal = 16'hFFFF;
    endcase
  end

  // no pull on the data lines, so an idle bus shows the inverse of the last word
  always @(posedge pins.oeN) lastOut = rdVal;
  assign dqOut = (!pins.ceN && !pins.oeN) ? rdVal : ~lastOut;
endmodule

// *** test/testbench.sv ***
`timescale 1ns/1ps
module testbench;
  logic                ref_clk = 1'b0;
  logic                nrst = 1'b0;
  logic                psel = 1'b0;
  logic                penable = 1'b0;
  logic                pwrite = 1'b0;
  logic                clkEn = 1'b1;
  logic [7:0]          paddr = 8'h00;
  logic [31:0]         pwdata = 32'h0;
  logic [31:0]         prdata;
  logic                pready;
  logic                pslverr;
  flb_pkg::flb_pins_t  pins;
  logic [15:0]         modelDq;
  logic [15:0]         dqWire;
  int                  nMismatch = 0;
  int                  checksDone = 0;
  int                  cyc = 0;
  logic [31:0]         q;
  logic [31:0]         st;
  logic                perr;

  always #5 ref_clk = ~ref_clk;
  assign dqWire = pins.dqOe ? pins.dq : modelDq;

  flb_host_ctrl uut (.ref_clk(ref_clk), .nrst(nrst), .clkEn(clkEn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .flashPins(pins), .flashDqIn(dqWire));
  flb_flash_model flash (.pins(pins), .dqOut(modelDq));

  task automatic endOfTest();
    $display("checks %0d mismatches %0d", checksDone, nMismatch);
    if (nMismatch == 0 && checksDone > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 40000) begin
      nMismatch++;
      endOfTest();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checksDone++;
    if (got !== exp) begin
      nMismatch++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // ----------------------------------------------------------------------------
  // apb master, answer taken at the edge where pready is sampled high
  // ----------------------------------------------------------------------------
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    q = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask

  // one operation; st keeps the status at completion, q the read word
  // a hung operation is caught by the cycle ceiling
  task automatic op(input logic [3:0] code, input logic [22:0] ad, input logic [15:0] dat);
    apb(1'b1, flb_pkg::REG_ADDR, {9'h0, ad});
    apb(1'b1, flb_pkg::REG_WDATA, {16'h0, dat});
    apb(1'b1, flb_pkg::REG_CTRL, {27'h0, 1'b1, code});
    do begin
      apb(1'b0, flb_pkg::REG_STATUS, 32'h0);
    end while (q[0] !== 1'b0);
    st = q;
    apb(1'b1, flb_pkg::REG_STATUS, 32'h6);
    apb(1'b0, flb_pkg::REG_RDATA, 32'h0);
  endtask

  task automatic rd_chk(input logic [22:0] ad, input logic [15:0] exp);
    op(4'h6, ad, 16'h0000);
    chk(q, {16'h0, exp});
  endtask

  task automatic t_regs();
    apb(1'b0, flb_pkg::REG_STATUS, 32'h0);
    chk(q, 32'h0);
    apb(1'b1, 8'h14, 32'hFFFF);
    chk({31'h0, perr}, 32'h1);
    op(4'h5, 23'h0, 16'h0000);
    chk({29'h0, st[2:0]}, 32'h4);
    $display("test regs done");
  endtask

  // freeze in mid write strobe: the pins must hold, then the set is left
  task automatic t_freeze();
    flb_pkg::flb_pins_t held;
    apb(1'b1, flb_pkg::REG_CTRL, 32'h10);
    repeat (4) @(posedge ref_clk);
    clkEn <= 1'b0;
    @(posedge ref_clk);
    held = pins;
    chk({30'h0, pins.ceN, pins.weN}, 32'h0);
    repeat (20) @(posedge ref_clk);
    chk({31'h0, pins === held}, 32'h1);
    clkEn <= 1'b1;
    do begin
      apb(1'b0, flb_pkg::REG_STATUS, 32'h0);
    end while (q[0] !== 1'b0);
    chk({31'h0, q[3]}, 32'h1);
    op(4'h8, 23'h0, 16'h0);
    chk({31'h0, st[3]}, 32'h0);
    $display("test freeze done");
  endtask

  task automatic t_lock();
    op(4'h0, 23'h0, 16'h0);
    chk({31'h0, st[3]}, 32'h1);
    op(4'h1, 23'h0, 16'h0);
    chk({31'h0, st[2]}, 32'h1);
    op(4'h6, 23'h0, 16'h0);
    chk({29'h0, q[2:0]}, 32'h7);
    op(4'h5, 23'h0, 16'hFFFE);
    op(4'h6, 23'h0, 16'h0);
    chk({29'h0, q[2:0]}, 32'h6);
    op(4'h5, 23'h0, 16'h0005);
    op(4'h6, 23'h0, 16'h0);
    chk({29'h0, q[2:0]}, 32'h4);
    op(4'h5, 23'h0, 16'hFFFB);
    op(4'h6, 23'h0, 16'h0);
    chk({29'h0, q[2:0]}, 32'h4);
    op(4'h8, 23'h0, 16'h0);
    chk({31'h0, st[3]}, 32'h0);
    $display("test lock done");
  endtask

  task automatic t_guard();
    op(4'h1, 23'h0, 16'h0);
    op(4'h5, 23'h000001, 16'h1234);
    rd_chk(23'h000001, 16'h1234);
    op(4'h8, 23'h0, 16'h0);
    op(4'h2, 23'h0, 16'h0);
    op(4'h5, 23'h010000, 16'h0000);
    rd_chk(23'h010000, 16'h0001);
    rd_chk(23'h020000, 16'h0000);
    op(4'h7, 23'h0, 16'h0);
    rd_chk(23'h010000, 16'h0000);
    op(4'h5, 23'h010000, 16'h0000);
    op(4'h8, 23'h0, 16'h0);
    op(4'h4, 23'h0, 16'h0);
    op(4'h5, 23'h020000, 16'h0000);
    rd_chk(23'h020000, 16'h0001);
    op(4'h5, 23'h020000, 16'h0001);
    rd_chk(23'h020000, 16'h0000);
    op(4'h8, 23'h0, 16'h0);
    op(4'h3, 23'h0, 16'h0);
    rd_chk(23'h0, 16'h0001);
    op(4'h5, 23'h0, 16'h0000);
    rd_chk(23'h0, 16'h0000);
    op(4'h8, 23'h0, 16'h0);
    op(4'h2, 23'h0, 16'h0);
    op(4'h7, 23'h0, 16'h0);
    rd_chk(23'h010000, 16'h0001);
    op(4'h5, 23'h030000, 16'h0000);
    rd_chk(23'h030000, 16'h0000);
    op(4'h8, 23'h0, 16'h0);
    $display("test guard done");
  endtask

  initial begin
    repeat (5) @(posedge ref_clk);
    nrst <= 1'b1;
    @(posedge ref_clk);
    t_regs();
    t_freeze();
    t_lock();
    t_guard();
    endOfTest();
  end
endmodule
